// [logic/asr_field_if.sv]
// Interface carrying one attribute field's write strobe, data and stored value
interface asr_field_if;
	logic wr_en;
	logic [15:0] wr_data;
	logic [15:0] value;
	modport bank(output wr_en, output wr_data, input value);
	modport field(input wr_en, input wr_data, output value);
endinterface

// [logic/asr_field_reg.sv]
// One writable attribute field of parameterised width, reset to zero
module asr_field_reg
	import asr_pkg::*;
#(
	parameter int WIDTH = 16
) (
	input wire logic clk,
	input wire logic reset,
	asr_field_if.field port
);
	logic [WIDTH-1:0] value_ff;
	logic [WIDTH-1:0] nxt_value;

	assign nxt_value = port.wr_en ? port.wr_data[WIDTH-1:0] : value_ff;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			value_ff <= ASR_ATTR_RESET[WIDTH-1:0];
		end else begin
			value_ff <= nxt_value;
		end
	end

	if (WIDTH < 16) begin : g_pad
		assign port.value = {{(16-WIDTH){1'b0}}, value_ff};
	end else begin : g_full
		assign port.value = value_ff;
	end
endmodule

// [logic/asr_pkg.sv]
// Package with register map, field layout and reset values of the stream attribute bank
package asr_pkg;
	localparam int ASR_ADDR_W = 12;
	localparam logic [11:0] ASR_OFS_INT_MASK = 12'h144;
	localparam logic [11:0] ASR_OFS_REPLY_BYTES = 12'h148;
	localparam logic [11:0] ASR_OFS_REPLY_COND = 12'h14C;
	localparam logic [11:0] ASR_OFS_HPD_LEN = 12'h150;
	localparam logic [11:0] ASR_OFS_HTOTAL = 12'h180;
	localparam logic [11:0] ASR_OFS_VTOTAL = 12'h184;
	localparam logic [11:0] ASR_OFS_POLARITY = 12'h188;
	localparam logic [11:0] ASR_OFS_HSWIDTH = 12'h18C;
	localparam logic [11:0] ASR_OFS_VSWIDTH = 12'h190;
	localparam logic [11:0] ASR_OFS_HRES = 12'h194;
	localparam logic [11:0] ASR_OFS_VRES = 12'h198;
	localparam logic [11:0] ASR_OFS_HSTART = 12'h19C;
	localparam logic [11:0] ASR_OFS_VSTART = 12'h1A0;
	localparam logic [11:0] ASR_OFS_MISC0 = 12'h1A4;
	localparam int ASR_NUM_ATTR = 10;
	// Interrupt mask bits held in this bank
	localparam int ASR_MASK_W = 3;
	localparam int ASR_MASK_REPLY_RX_BIT = 2;
	localparam int ASR_MASK_HOTPLUG_CHANGE_EVENT_BIT = 1;
	localparam int ASR_MASK_HOTPLUG_IRQ_PULSE_BIT = 0;
	localparam logic [2:0] ASR_MASK_RESET = 3'h7;
	// Reply condition layout
	localparam int ASR_COND_STATE_LSB = 4;
	localparam int ASR_COND_STATE_W = 8;
	localparam int ASR_COND_ERR_BIT = 3;
	localparam int ASR_COND_REQ_BIT = 2;
	localparam int ASR_COND_RPL_BIT = 1;
	localparam int ASR_COND_DONE_BIT = 0;
	localparam int ASR_REPLY_CNT_W = 5;
	localparam int ASR_HPD_LEN_W = 16;
	// Attribute field widths
	localparam int ASR_W16 = 16;
	localparam int ASR_W15 = 15;
	localparam int ASR_W_POL = 2;
	localparam int ASR_W_MISC0 = 8;
	localparam int ASR_POL_V_BIT = 1;
	localparam int ASR_POL_H_BIT = 0;
	localparam int ASR_MISC_SYNC_BIT = 0;
	localparam int ASR_MISC_FMT_LSB = 1;
	localparam int ASR_MISC_RANGE_BIT = 3;
	localparam int ASR_MISC_YCC_BIT = 4;
	localparam int ASR_MISC_DEPTH_LSB = 5;
	localparam logic [15:0] ASR_ATTR_RESET = 16'h0000;
endpackage

// [logic/asr_regs.sv]
// Register bank for AUX reply status, hot-plug pulse length and main stream attributes
// Functional notes
// - Mask bits 2,1,0 mask reply-received, hot-plug event, hot-plug IRQ interrupts.
// - A set mask bit blocks interrupt output only, not status recording.
// - Interrupt mask resets to all ones, every source masked.
// - Byte count at 0x148 bits 4:0 counts received reply bytes, not header.
// - Reply status 0x14C: bits 15:12 reserved, 11:4 reply state machine.
// - Reply status bit 3 set on error in latest reply.
// - Reply status bit 2 high while request is being sent.
// - Reply status bit 1 high while reply is being received.
// - Bit 0 clears when request starts; sets on complete valid reply.
// - 0x150 bits 15:0 give last hot-plug pulse length in microseconds.
// - 0x180 bits 15:0 hold horizontal total in clocks.
// - 0x184 bits 15:0 hold lines per frame.
// - 0x188 bit 1 vertical sync polarity, bit 0 horizontal sync polarity.
// - 0x18C bits 14:0 hold horizontal sync width in clocks.
// - 0x190 bits 14:0 hold vertical sync width in lines.
// - 0x194 bits 15:0 hold active pixels per line.
// - 0x198 bits 15:0 hold active lines.
// - 0x19C bits 15:0 hold clocks from hsync edge to first pixel.
// - 0x1A0 bits 15:0 hold lines from vsync edge to first line.
// - 0x1A4 holds sync clock, format, range, colorimetry, bit depth fields.
module asr_regs
	import asr_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [11:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	output logic [31:0] reg_rdata,
	input wire logic aux_req_start,
	input wire logic aux_req_busy,
	input wire logic aux_reply_busy,
	input wire logic aux_reply_byte,
	input wire logic aux_reply_valid,
	input wire logic aux_reply_error,
	input wire logic [7:0] aux_reply_state,
	input wire logic hpd_len_valid,
	input wire logic [15:0] hpd_len_us,
	input wire logic [2:0] irq_status_raw,
	output logic [2:0] irq_unmasked,
	output logic [15:0] stream_horizontal_total,
	output logic [15:0] stream_vertical_total,
	output logic stream_vsync_polarity,
	output logic stream_hsync_polarity,
	output logic [14:0] stream_hsync_width,
	output logic [14:0] stream_vsync_width,
	output logic [15:0] stream_active_width,
	output logic [15:0] stream_active_height,
	output logic [15:0] stream_horizontal_start,
	output logic [15:0] stream_vertical_start,
	output logic stream_sync_clock,
	output logic [1:0] stream_component_format,
	output logic stream_dynamic_range,
	output logic stream_ycbcr_colorimetry,
	output logic [2:0] stream_bit_depth
);
	localparam logic [11:0] ATTR_OFS [ASR_NUM_ATTR] = '{
		ASR_OFS_HTOTAL, ASR_OFS_VTOTAL, ASR_OFS_POLARITY, ASR_OFS_HSWIDTH,
		ASR_OFS_VSWIDTH, ASR_OFS_HRES, ASR_OFS_VRES, ASR_OFS_HSTART,
		ASR_OFS_VSTART, ASR_OFS_MISC0};
	localparam int ATTR_W [ASR_NUM_ATTR] = '{
		ASR_W16, ASR_W16, ASR_W_POL, ASR_W15, ASR_W15,
		ASR_W16, ASR_W16, ASR_W16, ASR_W16, ASR_W_MISC0};

	logic [ASR_MASK_W-1:0] irq_mask_ff;
	logic [ASR_MASK_W-1:0] nxt_irq_mask;
	logic [ASR_REPLY_CNT_W-1:0] reply_bytes_ff;
	logic [ASR_REPLY_CNT_W-1:0] nxt_reply_bytes;
	logic reply_error_ff;
	logic nxt_reply_error;
	logic reply_done_ff;
	logic nxt_reply_done;
	logic [ASR_HPD_LEN_W-1:0] hpd_len_ff;
	logic [ASR_HPD_LEN_W-1:0] nxt_hpd_len;
	logic [31:0] nxt_rdata;
	logic [15:0] attr_value [ASR_NUM_ATTR];
	logic [ASR_NUM_ATTR-1:0] attr_hit;
	logic [15:0] attr_rdata;
	logic hit_mask;
	logic hit_bytes;
	logic hit_cond;
	logic hit_hpd;
	logic [31:0] cond_word;
	logic reply_start;

	// Interrupt mask: set bit blocks that source from the interrupt output only
	assign hit_mask = (reg_addr == ASR_OFS_INT_MASK);
	assign nxt_irq_mask = (reg_wr && hit_mask) ? reg_wdata[ASR_MASK_W-1:0] : irq_mask_ff;
	assign irq_unmasked[ASR_MASK_REPLY_RX_BIT] = irq_status_raw[ASR_MASK_REPLY_RX_BIT] &
		~irq_mask_ff[ASR_MASK_REPLY_RX_BIT];
	assign irq_unmasked[ASR_MASK_HOTPLUG_CHANGE_EVENT_BIT] = irq_status_raw[ASR_MASK_HOTPLUG_CHANGE_EVENT_BIT] &
		~irq_mask_ff[ASR_MASK_HOTPLUG_CHANGE_EVENT_BIT];
	assign irq_unmasked[ASR_MASK_HOTPLUG_IRQ_PULSE_BIT] = irq_status_raw[ASR_MASK_HOTPLUG_IRQ_PULSE_BIT] &
		~irq_mask_ff[ASR_MASK_HOTPLUG_IRQ_PULSE_BIT];

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			irq_mask_ff <= ASR_MASK_RESET;
		end else begin
			irq_mask_ff <= nxt_irq_mask;
		end
	end

	// Reply byte counter restarts with each new request, counts received data bytes
	assign reply_start = aux_req_start;
	assign nxt_reply_bytes = reply_start ? '0 :
		(aux_reply_byte && reply_bytes_ff != '1) ? reply_bytes_ff + 5'h01 :
		reply_bytes_ff;

	// Error flag and received flag; a new request clears both, an error or a valid error-free reply sets its flag and wins over the clear
	assign nxt_reply_error = aux_reply_error ? 1'b1 :
		reply_start ? 1'b0 : reply_error_ff;
	assign nxt_reply_done = (aux_reply_valid && !aux_reply_error) ? 1'b1 :
		reply_start ? 1'b0 : reply_done_ff;

	// Pulse length is captured when the detector finishes a measurement
	assign nxt_hpd_len = hpd_len_valid ? hpd_len_us : hpd_len_ff;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			reply_bytes_ff <= '0;
			reply_error_ff <= 1'b0;
			reply_done_ff <= 1'b0;
			hpd_len_ff <= '0;
		end else begin
			reply_bytes_ff <= nxt_reply_bytes;
			reply_error_ff <= nxt_reply_error;
			reply_done_ff <= nxt_reply_done;
			hpd_len_ff <= nxt_hpd_len;
		end
	end

	// Stream attribute fields
	for (genvar i = 0; i < ASR_NUM_ATTR; i++) begin : g_attr
		asr_field_if fld ();
		assign attr_hit[i] = (reg_addr == ATTR_OFS[i]);
		assign fld.wr_en = reg_wr && attr_hit[i];
		assign fld.wr_data = reg_wdata[15:0];
		assign attr_value[i] = fld.value;
		asr_field_reg #(
			.WIDTH(ATTR_W[i])
		) u_field (
			.clk(clk),
			.reset(reset),
			.port(fld)
		);
	end

	assign stream_horizontal_total = attr_value[0];
	assign stream_vertical_total = attr_value[1];
	assign stream_vsync_polarity = attr_value[2][ASR_POL_V_BIT];
	assign stream_hsync_polarity = attr_value[2][ASR_POL_H_BIT];
	assign stream_hsync_width = attr_value[3][14:0];
	assign stream_vsync_width = attr_value[4][14:0];
	assign stream_active_width = attr_value[5];
	assign stream_active_height = attr_value[6];
	assign stream_horizontal_start = attr_value[7];
	assign stream_vertical_start = attr_value[8];
	assign stream_sync_clock = attr_value[9][ASR_MISC_SYNC_BIT];
	assign stream_component_format = attr_value[9][ASR_MISC_FMT_LSB +: 2];
	assign stream_dynamic_range = attr_value[9][ASR_MISC_RANGE_BIT];
	assign stream_ycbcr_colorimetry = attr_value[9][ASR_MISC_YCC_BIT];
	assign stream_bit_depth = attr_value[9][ASR_MISC_DEPTH_LSB +: 3];

	// Attribute read mux: OR of the one field whose offset matches
	always_comb begin
		attr_rdata = '0;
		for (int k = 0; k < ASR_NUM_ATTR; k++) begin
			if (attr_hit[k]) begin
				attr_rdata = attr_rdata | attr_value[k];
			end
		end
	end

	// Reply condition word: live progress bits, sticky result bits, upper bits zero
	assign cond_word = {16'h0000, 4'h0,
		aux_reply_state,
		reply_error_ff,
		aux_req_busy,
		aux_reply_busy,
		reply_done_ff};

	assign hit_bytes = (reg_addr == ASR_OFS_REPLY_BYTES);
	assign hit_cond = (reg_addr == ASR_OFS_REPLY_COND);
	assign hit_hpd = (reg_addr == ASR_OFS_HPD_LEN);

	assign nxt_rdata = !reg_rd ? reg_rdata :
		hit_mask ? {29'h00000000, irq_mask_ff} :
		hit_bytes ? {27'h0000000, reply_bytes_ff} :
		hit_cond ? cond_word :
		hit_hpd ? {16'h0000, hpd_len_ff} :
		{16'h0000, attr_rdata};

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			reg_rdata <= '0;
		end else begin
			reg_rdata <= nxt_rdata;
		end
	end
endmodule

// [verif/asr_regs_assertions.sv]
// Concurrent checks on the ports of the stream attribute register bank
module asr_regs_assertions
	import asr_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [11:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic [31:0] reg_rdata,
	input wire logic aux_req_start,
	input wire logic aux_reply_valid,
	input wire logic aux_reply_error,
	input wire logic [7:0] aux_reply_state,
	input wire logic hpd_len_valid,
	input wire logic [15:0] hpd_len_us,
	input wire logic [2:0] irq_status_raw,
	input wire logic [2:0] irq_unmasked,
	input wire logic [15:0] stream_horizontal_total
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	sequence s_rd(a);
		reg_rd && reg_addr == a;
	endsequence
	property p_mask;
		reg_wr && reg_addr == ASR_OFS_INT_MASK |=>
			irq_unmasked == (irq_status_raw & ~3'($past(reg_wdata)));
	endproperty
	a_mask: assert property (p_mask) else $error("unmasked irq wrong");
	property p_rst;
		$past(reset) |-> irq_unmasked == 3'h0;
	endproperty
	a_rst: assert property (p_rst) else $error("irq open after reset");
	property p_htot;
		reg_wr && reg_addr == ASR_OFS_HTOTAL |=>
			stream_horizontal_total == 16'($past(reg_wdata));
	endproperty
	a_htot: assert property (p_htot) else $error("htotal not stored");
	property p_state;
		s_rd(ASR_OFS_REPLY_COND) |=> reg_rdata[31:12] == 20'h00000 &&
			reg_rdata[11:4] == $past(aux_reply_state);
	endproperty
	a_state: assert property (p_state) else $error("reply state field wrong");
	property p_start;
		aux_req_start && !aux_reply_valid && !aux_reply_error ##1
			s_rd(ASR_OFS_REPLY_COND) |=> reg_rdata[3] == 1'b0 && reg_rdata[0] == 1'b0;
	endproperty
	a_start: assert property (p_start) else $error("start did not clear");
	property p_done;
		aux_reply_valid && !aux_reply_error ##1 s_rd(ASR_OFS_REPLY_COND) |=> reg_rdata[0];
	endproperty
	a_done: assert property (p_done) else $error("done not set");
	property p_err;
		aux_reply_error ##1 s_rd(ASR_OFS_REPLY_COND) |=> reg_rdata[3];
	endproperty
	a_err: assert property (p_err) else $error("error not set");
	property p_hpd;
		hpd_len_valid ##1 s_rd(ASR_OFS_HPD_LEN) |=>
			reg_rdata == {16'h0000, $past(hpd_len_us, 2)};
	endproperty
	a_hpd: assert property (p_hpd) else $error("pulse length wrong");
endmodule
bind asr_regs asr_regs_assertions u_chk (.clk(clk), .reset(reset), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
	.aux_req_start(aux_req_start), .aux_reply_valid(aux_reply_valid),
	.aux_reply_error(aux_reply_error), .aux_reply_state(aux_reply_state),
	.hpd_len_valid(hpd_len_valid), .hpd_len_us(hpd_len_us), .irq_status_raw(irq_status_raw),
	.irq_unmasked(irq_unmasked), .stream_horizontal_total(stream_horizontal_total));

// [verif/asr_regs_bench.sv]
// Self-checking bench for the stream attribute register bank
module asr_regs_bench
	import asr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, aux_req_start = 1'b0;
	logic aux_req_busy = 1'b0, aux_reply_busy = 1'b0, aux_reply_byte = 1'b0;
	logic aux_reply_valid = 1'b0, aux_reply_error = 1'b0, hpd_len_valid = 1'b0;
	logic stream_vsync_polarity, stream_hsync_polarity, stream_sync_clock;
	logic stream_dynamic_range, stream_ycbcr_colorimetry;
	logic [1:0] stream_component_format;
	logic [2:0] stream_bit_depth, irq_unmasked, irq_status_raw = 3'h0;
	logic [7:0] aux_reply_state = 8'h00;
	logic [11:0] reg_addr = 12'h000;
	logic [14:0] stream_hsync_width, stream_vsync_width;
	logic [15:0] hpd_len_us = 16'h0000, stream_horizontal_total, stream_vertical_total;
	logic [15:0] stream_active_width, stream_active_height;
	logic [15:0] stream_horizontal_start, stream_vertical_start;
	logic [31:0] reg_wdata = 32'h0, reg_rdata;
	logic [11:0] ofs [13] = '{12'h148, 12'h14C, 12'h150, 12'h180, 12'h184, 12'h188,
		12'h18C, 12'h190, 12'h194, 12'h198, 12'h19C, 12'h1A0, 12'h1A4};
	logic [31:0] msk [13] = '{32'h0, 32'h0, 32'h0, 32'hFFFF, 32'hFFFF, 32'h3, 32'h7FFF,
		32'h7FFF, 32'hFFFF, 32'hFFFF, 32'hFFFF, 32'hFFFF, 32'hFF};
	int errors = 0;
	int checks = 0;
	always #50 clk = ~clk;
	asr_regs uut (.clk(clk), .reset(reset), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.aux_req_start(aux_req_start), .aux_req_busy(aux_req_busy),
		.aux_reply_busy(aux_reply_busy), .aux_reply_byte(aux_reply_byte),
		.aux_reply_valid(aux_reply_valid), .aux_reply_error(aux_reply_error),
		.aux_reply_state(aux_reply_state), .hpd_len_valid(hpd_len_valid),
		.hpd_len_us(hpd_len_us), .irq_status_raw(irq_status_raw),
		.irq_unmasked(irq_unmasked), .stream_horizontal_total(stream_horizontal_total),
		.stream_vertical_total(stream_vertical_total),
		.stream_vsync_polarity(stream_vsync_polarity),
		.stream_hsync_polarity(stream_hsync_polarity),
		.stream_hsync_width(stream_hsync_width), .stream_vsync_width(stream_vsync_width),
		.stream_active_width(stream_active_width),
		.stream_active_height(stream_active_height),
		.stream_horizontal_start(stream_horizontal_start),
		.stream_vertical_start(stream_vertical_start),
		.stream_sync_clock(stream_sync_clock),
		.stream_component_format(stream_component_format),
		.stream_dynamic_range(stream_dynamic_range),
		.stream_ycbcr_colorimetry(stream_ycbcr_colorimetry),
		.stream_bit_depth(stream_bit_depth));
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task go;
		@(negedge clk);
		{reg_wr, reg_rd, aux_req_start, aux_reply_valid, aux_reply_error} = 5'h00;
		{hpd_len_valid, aux_reply_byte} = 2'h0;
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		go;
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
	endtask
	task rd(input logic [11:0] a, input logic [31:0] e);
		go;
		reg_rd = 1'b1;
		reg_addr = a;
		go;
		chk($sformatf("rdata_%h", a), e, reg_rdata);
	endtask
	task bytes(input int n);
		for (int i = 0; i < n; i++) begin
			go;
			aux_reply_byte = 1'b1;
			go;
		end
	endtask
	task t_reset;
		irq_status_raw = 3'h7;
		go;
		chk("irq_unmasked", 32'h0, {29'h0, irq_unmasked});
		rd(ASR_OFS_INT_MASK, 32'h7);
		for (int i = 0; i < 13; i++) rd(ofs[i], 32'h0);
	endtask
	task t_attr;
		for (int i = 0; i < 13; i++) wr(ofs[i], {16'hFFFF, 4'h0, ofs[i]});
		for (int i = 0; i < 13; i++) rd(ofs[i], msk[i] & {20'h0, ofs[i]});
		chk("totals", {16'h0180, 16'h0184}, {stream_horizontal_total, stream_vertical_total});
		chk("active", {16'h0194, 16'h0198}, {stream_active_width, stream_active_height});
		chk("start", {16'h019C, 16'h01A0}, {stream_horizontal_start, stream_vertical_start});
		chk("sync_width", {2'h0, 15'h018C, 15'h0190}, {2'h0, stream_hsync_width, stream_vsync_width});
		wr(ASR_OFS_POLARITY, 32'hFFFFFFFE);
		wr(ASR_OFS_MISC0, 32'hFFFFFF59);
		wr(12'h1A8, 32'hFFFFFFFF);
		rd(12'h1A8, 32'h0);
		chk("polarity", 32'h2, {30'h0, stream_vsync_polarity, stream_hsync_polarity});
		chk("misc0", 32'h59, {24'h0, stream_bit_depth, stream_ycbcr_colorimetry,
			stream_dynamic_range, stream_component_format, stream_sync_clock});
	endtask
	task t_mask;
		for (int i = 0; i < 3; i++) begin
			wr(ASR_OFS_INT_MASK, 32'h7 ^ (32'h1 << i));
			go;
			chk("irq_unmasked", 32'h1 << i, {29'h0, irq_unmasked});
		end
	endtask
	task t_aux;
		aux_reply_state = 8'hC3;
		aux_req_busy = 1'b1;
		rd(ASR_OFS_REPLY_COND, 32'h00000C34);
		aux_req_busy = 1'b0;
		aux_reply_busy = 1'b1;
		rd(ASR_OFS_REPLY_COND, 32'h00000C32);
		go;
		aux_reply_valid = 1'b1;
		rd(ASR_OFS_REPLY_COND, 32'h00000C33);
		go;
		aux_reply_error = 1'b1;
		rd(ASR_OFS_REPLY_COND, 32'h00000C3B);
		bytes(3);
		rd(ASR_OFS_REPLY_BYTES, 32'h3);
		go;
		aux_req_start = 1'b1;
		rd(ASR_OFS_REPLY_COND, 32'h00000C32);
		rd(ASR_OFS_REPLY_BYTES, 32'h0);
		bytes(35);
		rd(ASR_OFS_REPLY_BYTES, 32'h1F);
		// Set beats the start-clear when both land in one cycle
		go;
		aux_req_start = 1'b1;
		aux_reply_error = 1'b1;
		rd(ASR_OFS_REPLY_COND, 32'h00000C3A);
		go;
		aux_req_start = 1'b1;
		aux_reply_valid = 1'b1;
		rd(ASR_OFS_REPLY_COND, 32'h00000C33);
	endtask
	task t_hpd;
		go;
		hpd_len_us = 16'hBEEF;
		hpd_len_valid = 1'b1;
		rd(ASR_OFS_HPD_LEN, 32'h0000BEEF);
		hpd_len_us = 16'h1234;
		rd(ASR_OFS_HPD_LEN, 32'h0000BEEF);
	endtask
	task end_of_test;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		repeat (20) @(negedge clk);
		reset = 1'b0;
		t_reset;
		t_attr;
		t_mask;
		t_aux;
		t_hpd;
		end_of_test;
	end
endmodule
